/* rtl/msc_coder.sv */
// Purpose: Sample front end and frame scheduler of a multi-rate speech coder.
// Assumes: Samples arrive at 8 kHz as strobes synchronous to clk.
// Notes: The numeric analysis is external; this block sequences it and serialises the frame bits.
//
// Operation
// R1: Input samples carry 13 bits, left justified.
// R2: Low three input bits are zero.
// R3: Decoded output uses the same 16-bit layout.
// R4: Uniform samples are two's complement.
// R5: Source delivers one sample per 8 kHz period.
// R6: Companded codes expand to 13 bits, recompress out.
// R7: Eight selectable operating rates.
// R8: Frames of 160 samples, one parameter set.
// R9: Four subframes of 40 samples each.
// R10: Frame bit count fixed per rate.
// R11: Each parameter is sent MSB first.
// R12: Synthesis filter order is ten.
// R13: Weighting numerator 0.9 or 0.94, denominator 0.6.
// R14: Weighting uses unquantized coefficients.
// R15: Prediction analysis twice at top rate, else once.
// R16: Top rate: joint matrix quantization, 38 bits.
// R17: Other rates: split vector quantization.
// R18: Open-loop pitch every other subframe, lowest two once.
// R19: Pitch resolution sixth or third of a sample.
// R20: Gains scalar 4+5 bits or vector 6-7 bits.
// R21: Excitation is sum of scaled codebook vectors.
// R22: Subframe steps run in fixed order.
// R23: Rate latched at frame boundary.
`timescale 1ns/100ps
module msc_coder (
    input wire logic clk,                 // 25 MHz clock
    input wire logic reset,               // sync reset, active high
    input wire logic [2:0] rate_sel,      // requested rate code
    input wire logic [1:0] in_format,     // linear, A-law or mu-law
    input wire logic in_valid,            // input sample strobe
    input wire logic [15:0] in_sample,    // linear sample or law code in low byte
    output logic in_ready,                // FIFO has room
    input wire logic step_done,           // external engine finished current step
    output logic [4:0] step_req,          // one-hot step in progress
    output logic [1:0] step_subframe,     // subframe being processed
    output logic [2:0] frame_rate,        // rate held for the frame
    output logic lpa_twice,               // two analyses this frame
    output logic lsp_joint,               // joint matrix quantization
    output logic pitch_sixth,             // one-sixth lag resolution
    output logic gain_scalar,             // separate scalar gain coding
    output logic ol_pitch_req,            // open-loop pitch due this subframe
    output logic [15:0] gamma1,           // weighting numerator factor Q15
    output logic [15:0] gamma2,           // weighting denominator factor Q15
    output logic lpc_unquant_wt,          // weighting built from unquantized set
    output logic [3:0] lpc_order,         // synthesis filter order
    output logic smp_valid,               // framed sample to analysis
    output logic [15:0] smp_data,         // 13-bit sample left justified
    output logic [7:0] smp_index,         // position in frame
    input wire logic par_valid,           // parameter bit from quantiser
    input wire logic par_bit,             // bit, already MSB first per parameter
    output logic par_ready,               // pulses after each bit taken
    output logic bit_valid,               // serial output strobe
    output logic bit_data,                // serial output bit
    output logic frame_end,               // last bit of frame
    input wire logic [12:0] dec_lin,      // decoded linear sample
    input wire logic dec_valid,           // decoded sample strobe
    output logic dec_out_valid,           // decoded output strobe
    output logic [15:0] dec_out           // decoded, formatted or compressed
);
    // ------------------------------------------------------------
    // Companding and frame bit count helpers
    // ------------------------------------------------------------
    function automatic logic [12:0] law_expand(input logic [7:0] c, input logic is_a);
        logic [7:0] v;
        logic [12:0] mag;
        logic [2:0] seg;
        logic [13:0] wide;
        v = is_a ? (c ^ msc_pkg::ALAW_XOR) : ~c;
        seg = v[6:4];
        mag = '0;
        if (is_a) begin
            mag = (seg == 3'h0) ? {8'h00, v[3:0], 1'b1} : (13'({1'b1, v[3:0], 1'b1}) << (seg - 3'h1));
        end else begin
            // Mu-law is decoded on the 14-bit scale and halved, so the bias cancels exactly.
            wide = (14'({1'b1, v[3:0], 1'b1}) << seg) - 14'd33;
            mag = 13'(wide >> 1);
        end
        law_expand = v[7] == is_a ? mag : 13'(-mag);
    endfunction
    function automatic logic [7:0] law_compress(input logic [12:0] s, input logic is_a);
        logic [12:0] mag;
        logic [2:0] seg;
        logic [3:0] man;
        logic neg;
        neg = s[12];
        mag = neg ? 13'(-s) : s;
        if (!is_a) begin
            mag = 13'((mag >= 13'h0FDF) ? 13'h0FDF : mag) + 13'(msc_pkg::ULAW_BIAS >> 3);
        end
        seg = 3'h0;
        for (int i = 7; i >= 1; i--) begin
            if (seg == 3'h0 && mag[i+4]) begin
                seg = 3'(i);
            end
        end
        man = (seg == 3'h0 && is_a) ? mag[4:1] : 4'(mag >> seg);
        if (is_a) begin
            law_compress = {!neg, seg, man} ^ msc_pkg::ALAW_XOR;
        end else begin
            law_compress = ~{neg, seg, man};
        end
    endfunction
    function automatic logic [8:0] frame_bits(input logic [2:0] r);
        case (r)
            msc_pkg::RATE_4K75: frame_bits = 9'd95;
            msc_pkg::RATE_5K15: frame_bits = 9'd103;
            msc_pkg::RATE_5K90: frame_bits = 9'd118;
            msc_pkg::RATE_6K70: frame_bits = 9'd134;
            msc_pkg::RATE_7K40: frame_bits = 9'd148;
            msc_pkg::RATE_7K95: frame_bits = 9'd159;
            msc_pkg::RATE_10K2: frame_bits = 9'd204;
            default: frame_bits = 9'd244;
        endcase
    endfunction
    // ------------------------------------------------------------
    // Input conversion and FIFO
    // ------------------------------------------------------------
    wire is_law = in_format != msc_pkg::FMT_LINEAR;
    wire [12:0] exp_lin = law_expand(in_sample[7:0], in_format == msc_pkg::FMT_ALAW); // R6
    // Linear input keeps the top 13 bits; stray low bits are cleared rather than trusted.
    wire [15:0] conv_word = is_law ? {exp_lin, 3'b000} : {in_sample[15:3], 3'b000}; // R1 R2 R4
    wire fifo_ovalid;
    wire [15:0] fifo_odata;
    logic fifo_take;
    msc_fifo #(.WIDTH(msc_pkg::FIFO_W), .DEPTH(msc_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(conv_word),
        .out_valid(fifo_ovalid),
        .out_ready(fifo_take),
        .out_data(fifo_odata)
    );
    // ------------------------------------------------------------
    // Frame scheduler
    // ------------------------------------------------------------
    msc_pkg::msc_state_e st_q;
    msc_pkg::msc_step_e stp_q;
    logic [7:0] idx_q;
    logic [1:0] sf_q;
    logic [2:0] rate_q;
    logic [8:0] bit_cnt_q;
    logic [8:0] bit_total_q;
    wire top_rate = rate_q == msc_pkg::RATE_12K2;
    wire low_rate = rate_q <= msc_pkg::RATE_5K15;
    wire last_sample = idx_q == 8'(msc_pkg::FRAME_LEN - 1);
    wire sf_last = sf_q == 2'(msc_pkg::SUBFRAMES - 1);
    assign fifo_take = (st_q == msc_pkg::MSC_COLLECT) || (st_q == msc_pkg::MSC_IDLE);
    wire take = fifo_take && fifo_ovalid;
    wire bit_go = (st_q == msc_pkg::MSC_EMIT) && par_valid && !bit_valid;
    wire bits_last = bit_cnt_q == bit_total_q - 9'd1;
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= msc_pkg::MSC_IDLE;
            stp_q <= msc_pkg::STEP_TARGET;
            idx_q <= '0;
            sf_q <= '0;
            rate_q <= msc_pkg::RATE_12K2;
            bit_cnt_q <= '0;
            bit_total_q <= 9'd244;
        end else begin
            case (st_q)
                msc_pkg::MSC_IDLE: begin
                    if (take) begin
                        rate_q <= rate_sel; // R23 R7
                        bit_total_q <= frame_bits(rate_sel); // R10
                        idx_q <= 8'd1;
                        st_q <= msc_pkg::MSC_COLLECT;
                    end
                end
                msc_pkg::MSC_COLLECT: begin
                    if (take) begin
                        idx_q <= idx_q + 8'd1;
                        if (last_sample) begin // R8
                            sf_q <= '0;
                            stp_q <= msc_pkg::STEP_TARGET;
                            st_q <= msc_pkg::MSC_STEP;
                        end
                    end
                end
                msc_pkg::MSC_STEP: begin
                    if (step_done) begin
                        case (stp_q) // R22
                            msc_pkg::STEP_TARGET: stp_q <= msc_pkg::STEP_PITCH;
                            msc_pkg::STEP_PITCH: stp_q <= msc_pkg::STEP_REMOVE;
                            msc_pkg::STEP_REMOVE: stp_q <= msc_pkg::STEP_FIXED;
                            msc_pkg::STEP_FIXED: stp_q <= msc_pkg::STEP_UPDATE;
                            default: begin
                                stp_q <= msc_pkg::STEP_TARGET;
                                sf_q <= sf_q + 2'd1; // R9
                                if (sf_last) begin
                                    bit_cnt_q <= '0;
                                    st_q <= msc_pkg::MSC_EMIT;
                                end
                            end
                        endcase
                    end
                end
                msc_pkg::MSC_EMIT: begin
                    if (bit_go) begin
                        bit_cnt_q <= bit_cnt_q + 9'd1;
                        if (bits_last) begin
                            idx_q <= '0;
                            st_q <= msc_pkg::MSC_IDLE;
                        end
                    end
                end
                default: st_q <= msc_pkg::MSC_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    wire in_step = st_q == msc_pkg::MSC_STEP;
    // Low rates estimate once per frame, others on even subframes.
    wire ol_due = in_step && !step_done && (stp_q == msc_pkg::STEP_PITCH) && (low_rate ? sf_q == 2'd0 : !sf_q[0]); // R18
    always_ff @(posedge clk) begin
        if (reset) begin
            step_req <= '0;
            step_subframe <= '0;
            frame_rate <= msc_pkg::RATE_12K2;
            lpa_twice <= 1'b0;
            lsp_joint <= 1'b0;
            pitch_sixth <= 1'b0;
            gain_scalar <= 1'b0;
            ol_pitch_req <= 1'b0;
            gamma1 <= msc_pkg::GAMMA1_HI;
            gamma2 <= msc_pkg::GAMMA2;
            lpc_unquant_wt <= 1'b1;
            lpc_order <= '0;
            smp_valid <= 1'b0;
            smp_data <= '0;
            smp_index <= '0;
            bit_valid <= 1'b0;
            bit_data <= 1'b0;
            frame_end <= 1'b0;
            par_ready <= 1'b0;
            dec_out_valid <= 1'b0;
            dec_out <= '0;
        end else begin
            step_req <= (in_step && !step_done) ? stp_q : 5'h00; // R22
            step_subframe <= sf_q;
            frame_rate <= rate_q;
            lpa_twice <= top_rate; // R15
            lsp_joint <= top_rate; // R16 R17
            pitch_sixth <= top_rate; // R19
            gain_scalar <= top_rate || rate_q == msc_pkg::RATE_7K95; // R20 R21
            ol_pitch_req <= ol_due;
            gamma1 <= (rate_q >= msc_pkg::RATE_10K2) ? msc_pkg::GAMMA1_HI : msc_pkg::GAMMA1_LO; // R13
            gamma2 <= msc_pkg::GAMMA2; // R13
            lpc_unquant_wt <= 1'b1; // R14
            lpc_order <= 4'(msc_pkg::LPC_ORDER); // R12
            smp_valid <= take;
            smp_data <= fifo_odata;
            smp_index <= (st_q == msc_pkg::MSC_IDLE) ? 8'd0 : idx_q;
            // Bits pass straight through, so each parameter keeps its MSB-first order.
            bit_valid <= bit_go; // R11
            bit_data <= par_bit;
            frame_end <= bit_go && bits_last; // R10
            par_ready <= bit_go;
            dec_out_valid <= dec_valid;
            if (in_format == msc_pkg::FMT_LINEAR) begin
                dec_out <= {dec_lin, 3'b000}; // R3
            end else begin
                dec_out <= {8'h00, law_compress(dec_lin, in_format == msc_pkg::FMT_ALAW)}; // R6
            end
        end
    end
endmodule

/* inc/msc_pkg.sv */
// Purpose: Shared constants for the multi-rate speech frame coder front end.
// Assumes: 25 MHz clock, 8 kHz sample strobe supplied by the converter.
// Notes: Rate codes run from the lowest rate (0) to the highest (7).
package msc_pkg;
    localparam int SAMPLE_W = 16;
    localparam int LIN_W = 13;
    localparam int PAD_W = 3;
    localparam int LAW_W = 8;
    localparam int RATE_W = 3;
    localparam int SUBFRAME_LEN = 40;
    localparam int SUBFRAMES = 4;
    localparam int FRAME_LEN = 160;
    localparam int LPC_ORDER = 10;
    localparam int FRAME_MS = 20;
    localparam int CLK_HZ = 25000000;
    localparam int SAMPLE_HZ = 8000;
    localparam int CYC_PER_SAMPLE = CLK_HZ / SAMPLE_HZ;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W = SAMPLE_W;
    localparam int SMQ_BITS_12K2 = 38;
    // Rate codes.
    localparam logic [2:0] RATE_4K75 = 3'h0;
    localparam logic [2:0] RATE_5K15 = 3'h1;
    localparam logic [2:0] RATE_5K90 = 3'h2;
    localparam logic [2:0] RATE_6K70 = 3'h3;
    localparam logic [2:0] RATE_7K40 = 3'h4;
    localparam logic [2:0] RATE_7K95 = 3'h5;
    localparam logic [2:0] RATE_10K2 = 3'h6;
    localparam logic [2:0] RATE_12K2 = 3'h7;
    // Weighting factors in Q15.
    localparam logic [15:0] GAMMA1_HI = 16'h7333;
    localparam logic [15:0] GAMMA1_LO = 16'h7852;
    localparam logic [15:0] GAMMA2 = 16'h4CCD;
    // Input formats.
    localparam logic [1:0] FMT_LINEAR = 2'h0;
    localparam logic [1:0] FMT_ALAW = 2'h1;
    localparam logic [1:0] FMT_ULAW = 2'h2;
    localparam logic [7:0] ALAW_XOR = 8'h55;
    localparam logic [12:0] ULAW_BIAS = 13'h0084;
    typedef enum logic [3:0] {
        MSC_IDLE = 4'b0001,
        MSC_COLLECT = 4'b0010,
        MSC_STEP = 4'b0100,
        MSC_EMIT = 4'b1000
    } msc_state_e;
    typedef enum logic [4:0] {
        STEP_TARGET = 5'b00001,
        STEP_PITCH = 5'b00010,
        STEP_REMOVE = 5'b00100,
        STEP_FIXED = 5'b01000,
        STEP_UPDATE = 5'b10000
    } msc_step_e;
endpackage

/* rtl/msc_fifo.sv */
// Purpose: Small valid/ready FIFO in the sample path.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Full and empty are exact; no write while full, no read while empty.
`timescale 1ns/100ps
module msc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,               // clock
    input wire logic reset,             // sync reset
    input wire logic in_valid,          // write request
    output logic in_ready,              // space available
    input wire logic [WIDTH-1:0] in_data, // write data
    output logic out_valid,             // data available
    input wire logic out_ready,         // reader accepts
    output logic [WIDTH-1:0] out_data   // read data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;
    wire [AW:0] cnt_d = cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
        end else begin
            if (do_wr) begin
                mem_q[wr_q] <= in_data;
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            // Ready comes from the next count, so the port is a flop and still exact.
            in_ready <= cnt_d < (AW+1)'(DEPTH);
        end
    end
endmodule

/* bench/msc_chk.sv */
// Purpose: Port-level assertions for the speech frame coder.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to msc_coder below.
`timescale 1ns/100ps
module msc_chk (
    input wire logic clk,             // clock
    input wire logic reset,           // sync reset
    input wire logic step_done,       // engine done
    input wire logic [4:0] step_req,  // one-hot step
    input wire logic [1:0] step_subframe, // subframe
    input wire logic [2:0] frame_rate, // frame rate
    input wire logic lpa_twice,       // two analyses
    input wire logic lsp_joint,       // joint quant
    input wire logic ol_pitch_req,    // open-loop pitch
    input wire logic [15:0] gamma1,   // numerator
    input wire logic [3:0] lpc_order, // filter order
    input wire logic smp_valid,       // sample strobe
    input wire logic [15:0] smp_data, // sample
    input wire logic [7:0] smp_index, // position
    input wire logic par_bit,         // offered bit
    input wire logic par_ready,       // bit taken
    input wire logic bit_valid,       // serial strobe
    input wire logic bit_data,        // serial bit
    input wire logic frame_end,       // last bit
    input wire logic dec_valid,       // decoded in
    input wire logic dec_out_valid    // decoded out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    int bits_tab[8] = '{95, 103, 118, 134, 148, 159, 204, 244};
    logic [4:0] last_q;
    logic [7:0] bcnt_q;
    logic [4:0] next_step;
    logic top_rate;
    assign next_step = last_q == 5'h0 ? 5'h01 : {last_q[3:0], last_q[4]};
    assign top_rate = frame_rate == msc_pkg::RATE_12K2;
    always_ff @(posedge clk) begin
        last_q <= reset ? 5'h0 : (step_req != 5'h0 ? step_req : last_q);
        bcnt_q <= (reset || frame_end) ? 8'h0 : bcnt_q + {7'h0, bit_valid};
    end
    sequence s_step_ack;
        step_req != 5'h0 ##0 step_done;
    endsequence
    sequence s_bit_out;
        bit_valid ##0 bit_data == $past(par_bit);
    endsequence
    a_step_order: assert property (step_req != 5'h0 && step_req != last_q |-> step_req == next_step)
        else $error("step out of order");
    a_step_release: assert property (s_step_ack |=> step_req == 5'h0)
        else $error("step held after done");
    a_frame_bits: assert property (frame_end |-> bit_valid && 32'(bcnt_q) + 1 == bits_tab[frame_rate])
        else $error("frame bit count wrong");
    a_bit_order: assert property (par_ready |-> s_bit_out)
        else $error("serial bit differs from taken bit");
    a_dec_strobe: assert property (dec_out_valid |-> $past(dec_valid))
        else $error("decoded strobe without input");
    a_smp_layout: assert property (smp_valid |-> smp_data[2:0] == 3'h0 && smp_index < 8'd160)
        else $error("framed sample malformed");
    a_weight_rate: assert property (step_req != 5'h0 |-> gamma1 == (frame_rate > 3'h5 ? 16'h7333 : 16'h7852))
        else $error("weighting factor wrong");
    a_analysis_set: assert property (step_req != 5'h0 |-> lpa_twice == top_rate && lsp_joint == top_rate)
        else $error("analysis schedule wrong");
    a_filter_order: assert property (step_req != 5'h0 |-> lpc_order == 4'd10)
        else $error("filter order wrong");
    a_rate_hold: assert property (step_req != 5'h0 && step_subframe != 2'h0 |-> $stable(frame_rate))
        else $error("rate changed in frame");
    a_olpitch_slot: assert property (ol_pitch_req |-> step_req == 5'h02 &&
        (step_subframe == 2'h0 || step_subframe == 2'h2 && frame_rate > 3'h1))
        else $error("open-loop pitch in wrong slot");
endmodule
bind msc_coder msc_chk i_msc_chk (.*);

/* bench/msc_peer.sv */
// Purpose: Analysis engine and parameter quantiser behind the coder.
// Assumes: Outputs change on the falling edge.
// Notes: Bits follow a fixed pattern that the bench predicts.
`timescale 1ns/100ps
module msc_peer (
    input wire logic clk,            // clock
    input wire logic reset,          // sync reset
    input wire logic slow,           // stall mode
    input wire logic [4:0] step_req, // step asked
    input wire logic par_ready,      // bit taken
    input wire logic frame_end,      // last bit out
    output logic step_done,          // step finished
    output logic par_valid,          // bit offered
    output logic par_bit             // offered bit
);
    int cnt = 0;
    logic [7:0] idx = 8'h0;
    // In slow mode valid drops a cycle after each take, so the coder meets a stalling quantiser.
    always @(negedge clk) begin
        if (step_done || reset) begin
            step_done = 1'b0;
        end else if (step_req != 5'h0) begin
            cnt = cnt + 1;
            if (cnt >= (slow ? 30 : 1)) begin
                step_done = 1'b1;
                cnt = 0;
            end
        end
        if (frame_end || reset) idx = 8'h0;
        else if (par_ready) idx = idx + 8'h1;
        par_valid = !reset && !(slow && par_ready);
        par_bit = idx[0] ^ idx[3] ^ idx[6];
    end
endmodule

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the speech frame coder.
// Assumes: Inputs change on the falling edge of clk.
// Notes: Every rate is run, the lowest rate twice; the last frame starts from a full FIFO.
`timescale 1ns/100ps
module tb_top;
    logic clk = 0, reset = 1, in_valid = 0, dec_valid = 0, slow = 0;
    logic [2:0] rate_sel = 0, er = 7, frame_rate;
    logic [1:0] in_format = 0, step_subframe;
    logic [15:0] in_sample = 0, sv = 16'h8000, gamma1, gamma2, smp_data, dec_out;
    logic [12:0] dec_lin = 0;
    logic [4:0] step_req, ps = 0;
    logic [7:0] smp_index;
    logic [3:0] lpc_order;
    logic in_ready, step_done, lpa_twice, lsp_joint, pitch_sixth, gain_scalar, ol_pitch_req, olq;
    logic lpc_unquant_wt, smp_valid, par_valid, par_bit, par_ready, bit_valid, bit_data, frame_end, dec_out_valid;
    int error_cnt = 0, checked = 0, cyc = 0, st = 0, nb = 0, ni = 0;
    int bits_tab[8] = '{95, 103, 118, 134, 148, 159, 204, 244};
    logic [15:0] expq[$];
    msc_coder i_msc_coder (.*);
    msc_peer i_msc_peer (.*);
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    always @(negedge clk) begin
        if (smp_valid) begin
            chk({8'h0, smp_index}, 16'(ni));
            chk(smp_data, expq.pop_front());
            ni = (ni + 1) % 160;
        end
        if (step_req != 5'h0 && step_req != ps) begin
            chk({step_req, 1'b0, step_subframe}, {5'h01 << (st % 5), 1'b0, 2'(st / 5)});
            chk({frame_rate, lpa_twice, lsp_joint, pitch_sixth, gain_scalar, lpc_unquant_wt, lpc_order},
                {er, er == 7, er == 7, er == 7, er == 7 || er == 5, 1'b1, 4'd10});
            chk(gamma1, er > 3'h5 ? msc_pkg::GAMMA1_HI : msc_pkg::GAMMA1_LO);
            st++;
        end
        if (step_req == 5'h0 && ps == 5'h02) chk(olq, (st - 1) / 5 == 0 || (st - 1) / 5 == 2 && er > 3'h1);
        if (step_req != 5'h0) olq = ol_pitch_req;
        ps = step_req;
        if (bit_valid) begin
            chk(bit_data, nb[0] ^ nb[3] ^ nb[6]);
            chk(frame_end, nb + 1 == bits_tab[er]);
            nb++;
        end
    end
    task automatic push(input bit last);
        int w;
        w = 0;
        // Samples come back to back, far faster than the real sample period, to keep the run short.
        in_valid = 1'b1;
        in_sample = in_format == 2'h1 ? 16'hA5D5 : in_format == 2'h2 ? 16'hA5FF : sv;
        while (!in_ready && w < 400) begin
            @(negedge clk);
            w++;
        end
        if (w == 400) error_cnt++;
        expq.push_back(in_format == 2'h1 ? 16'h0008 : in_format == 2'h2 ? 16'h0000 : sv & 16'hFFF8);
        sv = sv + 16'h1238;
        @(negedge clk);
        if (last) in_valid = 1'b0;
    endtask
    task automatic frame(input logic [2:0] r, input logic [1:0] f, input bit fill, input int pre);
        int k;
        er = r;
        st = 0;
        nb = 0;
        in_format = f;
        slow = r[0];
        if (pre == 0) rate_sel = r;
        if (pre == 0) push(1);
        repeat (8) @(negedge clk);
        rate_sel = ~r;
        for (k = pre > 0 ? pre : 1; k < 160; k++) push(k == 159);
        if (fill) begin
            rate_sel = r + 3'h1;
            for (k = 0; step_req == 5'h0 && k < 400; k++) @(negedge clk);
            for (k = 0; k < 4; k++) push(k == 3);
            chk(in_ready, 1'b0);
        end
        for (k = 0; !frame_end && k < 5000; k++) @(negedge clk);
        @(negedge clk);
        chk(16'(nb), 16'(bits_tab[r]));
        chk(16'(st), 16'd20);
    endtask
    task automatic dec(input logic [1:0] f, input logic [12:0] v, input logic [15:0] e);
        in_format = f;
        dec_lin = v;
        dec_valid = 1'b1;
        @(negedge clk);
        dec_valid = 1'b0;
        chk(dec_out_valid, 1'b1);
        chk(dec_out, e);
    endtask
    initial begin
        repeat (5) @(negedge clk);
        reset = 0;
        chk(gamma1, 16'h7333);
        chk(gamma2, 16'h4CCD);
        chk({lpc_unquant_wt, frame_rate, step_req}, 16'h01E0);
        dec(2'h0, 13'h1000, 16'h8000);
        dec(2'h0, 13'h0FFF, 16'h7FF8);
        dec(2'h1, 13'h0001, 16'h00D5);
        dec(2'h2, 13'h0000, 16'h00FF);
        for (int r = 0; r < 8; r++) frame(3'(r), r == 3 ? 2'h1 : r == 4 ? 2'h2 : 2'h0, r == 7, 0);
        frame(3'h0, 2'h0, 1'b0, 4);
        tally_and_finish();
    end
endmodule
